// [core/analog_converter_control.sv]
// control logic of a 10-bit successive-approximation converter with APB registers
`timescale 1ns/1ps
module analog_converter_control
  import conv_ctrl_pkg::*;
(
  input  wire logic        REF_CLK_I,         // system clock, 125 MHz
  input  wire logic        RST_B_I,           // asynchronous reset, active low
  input  wire logic        PSEL_I,            // apb select
  input  wire logic        PENABLE_I,         // apb access phase
  input  wire logic        PWRITE_I,          // apb direction, high for write
  input  wire logic [31:0] PADDR_I,           // apb byte address
  input  wire logic [31:0] PWDATA_I,          // apb write data
  output logic      [31:0] PRDATA_O,          // apb read data
  output logic             PREADY_O,          // apb ready
  output logic             PSLVERR_O,         // apb error on unmapped address
  input  wire logic        TRIGGER_I,         // auto trigger source, asynchronous
  input  wire logic        IRQ_ACK_I,         // interrupt vector taken, clears done flag
  output logic             CONV_POWER_O,      // converter powered
  output logic             CONV_BUSY_O,       // conversion in progress
  output logic             CONV_INIT_O,       // initialising first conversion
  output logic             CONV_CLK_EN_O,     // one-cycle converter clock enable
  output logic             CONV_DONE_O,       // one-cycle pulse at completion
  output logic             CONV_IRQ_O,        // done flag gated by its enable
  output logic             REF_SUPPLY_O,      // supply used as reference
  output logic             REF_EXTERNAL_O,    // external reference pin used
  output logic             REF_INTERNAL_O,    // internal 1.1V reference used
  output logic             REF_PIN_DRIVE_O,   // internal reference driven onto pin
  output logic             DIFF_MODE_O,       // differential path selected
  output logic             GAIN_20X_O,        // gain stage at 20x
  output logic       [2:0] POS_INPUT_O,       // positive or single-ended input
  output logic       [2:0] NEG_INPUT_O,       // negative input in differential mode
  output logic             GROUND_SEL_O,      // analog ground selected
  output logic             BANDGAP_SEL_O,     // internal reference as input
  output logic             TEMP_SENSOR_EN_O   // temperature sensor channel enabled
);

  //////////////////////////////////////////////////////////////////////////////
  // declarations

  logic        trg_meta_reg;
  logic        trg_sync_reg;
  logic        trg_prev_reg;
  logic        enable_reg;
  logic        start_reg;
  logic        auto_trg_reg;
  logic        done_reg;
  logic        irq_en_reg;
  logic [2:0]  div_code_reg;
  logic [1:0]  ref_reg;
  logic [5:0]  sel_reg;
  logic        free_run_reg;
  logic [1:0]  ref_applied_reg;
  logic [5:0]  sel_applied_reg;
  logic        first_pending_reg;
  logic        init_reg;
  conv_state_t state_reg;
  logic [4:0]  cyc_reg;
  logic [4:0]  cyc_len_reg;
  logic [6:0]  presc_reg;
  logic        tick_reg;
  logic        done_pulse_reg;
  logic [31:0] rdata_reg;
  logic        slverr_reg;

  logic        setup_phase;
  logic        wr_access;
  logic        hit_ctrl;
  logic        hit_sel;
  logic        hit_mode;
  logic        wr_ctrl;
  logic        wr_sel;
  logic        wr_mode;
  logic        enable_next;
  logic        sw_start;
  logic        trg_start;
  logic        finish;
  logic        restart;
  logic        begin_conv;
  logic [7:0]  ctrl_view;

  //////////////////////////////////////////////////////////////////////////////
  // apb decode: zero wait states, read data captured during the setup phase, writes taken in the access phase

  assign setup_phase = PSEL_I & ~PENABLE_I;
  assign wr_access   = PSEL_I & PENABLE_I & PWRITE_I;
  assign hit_ctrl    = (PADDR_I == {22'h0, IDX_STATUS_CONTROL, 2'h0});
  assign hit_sel     = (PADDR_I == {22'h0, IDX_INPUT_REF_SEL, 2'h0});
  assign hit_mode    = (PADDR_I == {22'h0, IDX_MODE_CONTROL, 2'h0});
  assign wr_ctrl     = wr_access & hit_ctrl;
  assign wr_sel      = wr_access & hit_sel;
  assign wr_mode     = wr_access & hit_mode;
  assign PREADY_O    = 1'b1;
  assign PRDATA_O    = rdata_reg;
  assign PSLVERR_O   = slverr_reg;

  // start bit reads as the live conversion state
  assign ctrl_view = {enable_reg, start_reg, auto_trg_reg, done_reg,
                      irq_en_reg, div_code_reg};

  // read data and error are latched in setup so they stand through access
  always_ff @(posedge REF_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      rdata_reg  <= 32'h0;
      slverr_reg <= 1'b0;
    end else if (setup_phase) begin
      slverr_reg <= ~(hit_ctrl | hit_sel | hit_mode);
      if (hit_ctrl) begin
        rdata_reg <= {24'h0, ctrl_view};
      end else if (hit_sel) begin
        rdata_reg <= {24'h0, ref_reg, sel_reg};
      end else if (hit_mode) begin
        rdata_reg <= {31'h0, free_run_reg};
      end else begin
        rdata_reg <= 32'h0;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // software registers

  assign enable_next = wr_ctrl ? PWDATA_I[POS_ENABLE] : enable_reg;

  // plain control fields of the status/control register
  always_ff @(posedge REF_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      enable_reg   <= RST_STATUS_CONTROL[POS_ENABLE];
      auto_trg_reg <= RST_STATUS_CONTROL[POS_AUTO_TRG];
      irq_en_reg   <= RST_STATUS_CONTROL[POS_IRQ_EN];
      div_code_reg <= RST_STATUS_CONTROL[POS_DIV_LO +: 3];
    end else if (wr_ctrl) begin
      enable_reg   <= PWDATA_I[POS_ENABLE];
      auto_trg_reg <= PWDATA_I[POS_AUTO_TRG];
      irq_en_reg   <= PWDATA_I[POS_IRQ_EN];
      div_code_reg <= PWDATA_I[POS_DIV_LO +: 3];
    end
  end

  // written selection; the converter sees it only through the applied copy
  always_ff @(posedge REF_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      ref_reg <= RST_INPUT_REF_SEL[POS_REF_LO +: 2];
      sel_reg <= RST_INPUT_REF_SEL[POS_SEL_LO +: 6];
    end else if (wr_sel) begin
      ref_reg <= PWDATA_I[POS_REF_LO +: 2];
      sel_reg <= PWDATA_I[POS_SEL_LO +: 6];
    end
  end

  // free-running mode select
  always_ff @(posedge REF_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      free_run_reg <= RST_MODE_CONTROL[POS_FREE_RUN];
    end else if (wr_mode) begin
      free_run_reg <= PWDATA_I[POS_FREE_RUN];
    end
  end

  // done flag: a completion in the clearing cycle wins over the clear
  always_ff @(posedge REF_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      done_reg <= RST_STATUS_CONTROL[POS_DONE];
    end else if (finish) begin
      done_reg <= 1'b1;
    end else if ((wr_ctrl & PWDATA_I[POS_DONE]) | IRQ_ACK_I) begin
      done_reg <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // trigger input synchroniser and edge detect

  always_ff @(posedge REF_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      trg_meta_reg <= 1'b0;
      trg_sync_reg <= 1'b0;
      trg_prev_reg <= 1'b0;
    end else begin
      trg_meta_reg <= TRIGGER_I;
      trg_sync_reg <= trg_meta_reg;
      trg_prev_reg <= trg_sync_reg;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // prescaler: one-cycle enable at the converter clock rate

  always_ff @(posedge REF_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      presc_reg <= 7'h0;
      tick_reg  <= 1'b0;
    end else if (!enable_reg) begin
      presc_reg <= 7'h0;
      tick_reg  <= 1'b0;
    end else if ({1'b0, presc_reg} >= DIV_FACTOR[div_code_reg] - 8'h01) begin
      presc_reg <= 7'h0;
      tick_reg  <= 1'b1;
    end else begin
      presc_reg <= presc_reg + 7'h1;
      tick_reg  <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // conversion sequencing

  // a start needs the converter enabled after this cycle's write
  assign sw_start   = wr_ctrl & PWDATA_I[POS_START] & PWDATA_I[POS_ENABLE];
  assign trg_start  = auto_trg_reg & ~free_run_reg & trg_sync_reg & ~trg_prev_reg;
  assign finish     = (state_reg == ST_CONVERT) & enable_next & tick_reg
                      & (cyc_reg == cyc_len_reg - 5'h1);
  assign restart    = finish & auto_trg_reg & free_run_reg;
  assign begin_conv = (state_reg == ST_IDLE) & enable_next & (sw_start | trg_start);

  // the first conversion after enabling is marked for initialisation
  always_ff @(posedge REF_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      first_pending_reg <= 1'b0;
    end else if (!enable_next) begin
      first_pending_reg <= 1'b0;
    end else if (!enable_reg) begin
      first_pending_reg <= ~begin_conv;
    end else if (begin_conv) begin
      first_pending_reg <= 1'b0;
    end
  end

  // state, cycle count and length of the running conversion
  always_ff @(posedge REF_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      state_reg   <= ST_IDLE;
      cyc_reg     <= 5'h0;
      cyc_len_reg <= CONV_CYCLES_NORMAL;
      init_reg    <= 1'b0;
    end else if (!enable_next) begin
      state_reg <= ST_IDLE;
      cyc_reg   <= 5'h0;
      init_reg  <= 1'b0;
    end else begin
      unique case (state_reg)
        ST_IDLE: begin
          if (begin_conv) begin
            state_reg <= ST_CONVERT;
            cyc_reg   <= 5'h0;
            // enable written in this same cycle also counts as first
            if (first_pending_reg | ~enable_reg) begin
              cyc_len_reg <= CONV_CYCLES_FIRST;
              init_reg    <= 1'b1;
            end else begin
              cyc_len_reg <= CONV_CYCLES_NORMAL;
              init_reg    <= 1'b0;
            end
          end
        end
        ST_CONVERT: begin
          if (finish) begin
            cyc_reg     <= 5'h0;
            init_reg    <= 1'b0;
            cyc_len_reg <= CONV_CYCLES_NORMAL;
            state_reg   <= restart ? ST_CONVERT : ST_IDLE;
          end else if (tick_reg) begin
            cyc_reg <= cyc_reg + 5'h1;
          end
        end
      endcase
    end
  end

  // start bit mirrors the conversion; writing zero leaves it alone
  always_ff @(posedge REF_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      start_reg <= RST_STATUS_CONTROL[POS_START];
    end else if (!enable_next) begin
      start_reg <= 1'b0;
    end else if (begin_conv) begin
      start_reg <= 1'b1;
    end else if (finish) begin
      start_reg <= restart;
    end
  end

  // selection reaches the analog side only between conversions
  always_ff @(posedge REF_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      ref_applied_reg <= RST_INPUT_REF_SEL[POS_REF_LO +: 2];
      sel_applied_reg <= RST_INPUT_REF_SEL[POS_SEL_LO +: 6];
    end else if (state_reg == ST_IDLE || finish) begin
      ref_applied_reg <= wr_sel ? PWDATA_I[POS_REF_LO +: 2] : ref_reg;
      sel_applied_reg <= wr_sel ? PWDATA_I[POS_SEL_LO +: 6] : sel_reg;
    end
  end

  // completion pulse
  always_ff @(posedge REF_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      done_pulse_reg <= 1'b0;
    end else begin
      done_pulse_reg <= finish;
    end
  end

  assign CONV_POWER_O  = enable_reg;
  assign CONV_BUSY_O   = start_reg;
  assign CONV_INIT_O   = init_reg;
  assign CONV_CLK_EN_O = tick_reg;
  assign CONV_DONE_O   = done_pulse_reg;
  assign CONV_IRQ_O    = done_reg & irq_en_reg;

  //////////////////////////////////////////////////////////////////////////////
  // reference decode; code 11 puts the internal reference on the pin, so
  // nothing outside may drive that pin in this setting

  always_ff @(posedge REF_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      REF_SUPPLY_O    <= 1'b0;
      REF_EXTERNAL_O  <= 1'b0;
      REF_INTERNAL_O  <= 1'b0;
      REF_PIN_DRIVE_O <= 1'b0;
    end else begin
      REF_SUPPLY_O    <= (ref_applied_reg == REF_SUPPLY);
      REF_EXTERNAL_O  <= (ref_applied_reg == REF_EXTERNAL);
      REF_INTERNAL_O  <= (ref_applied_reg == REF_INTERNAL) |
                         (ref_applied_reg == REF_INT_PIN);
      REF_PIN_DRIVE_O <= (ref_applied_reg == REF_INT_PIN);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // channel decode

  // normal pair for index 0..11 as {positive, negative}
  function automatic logic [5:0] pair_of(input logic [3:0] idx);
    unique case (idx)
      4'h0:    pair_of = {3'h0, 3'h1};
      4'h1:    pair_of = {3'h0, 3'h3};
      4'h2:    pair_of = {3'h1, 3'h2};
      4'h3:    pair_of = {3'h1, 3'h3};
      4'h4:    pair_of = {3'h2, 3'h3};
      4'h5:    pair_of = {3'h3, 3'h4};
      4'h6:    pair_of = {3'h3, 3'h5};
      4'h7:    pair_of = {3'h3, 3'h6};
      4'h8:    pair_of = {3'h3, 3'h7};
      4'h9:    pair_of = {3'h4, 3'h5};
      4'ha:    pair_of = {3'h5, 3'h6};
      4'hb:    pair_of = {3'h6, 3'h7};
      default: pair_of = {3'h0, 3'h0};
    endcase
  endfunction

  // decoded selection is registered so the analog side sees clean levels
  always_ff @(posedge REF_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      DIFF_MODE_O      <= 1'b0;
      GAIN_20X_O       <= 1'b0;
      POS_INPUT_O      <= 3'h0;
      NEG_INPUT_O      <= 3'h0;
      GROUND_SEL_O     <= 1'b0;
      BANDGAP_SEL_O    <= 1'b0;
      TEMP_SENSOR_EN_O <= 1'b0;
    end else begin
      GROUND_SEL_O     <= (sel_applied_reg == SEL_GROUND);
      BANDGAP_SEL_O    <= (sel_applied_reg == SEL_BANDGAP);
      TEMP_SENSOR_EN_O <= (sel_applied_reg == SEL_TEMP);
      if (sel_applied_reg[5:3] == 3'h0) begin
        DIFF_MODE_O <= 1'b0;
        GAIN_20X_O  <= 1'b0;
        POS_INPUT_O <= sel_applied_reg[2:0];
        NEG_INPUT_O <= 3'h0;
      end else if (sel_applied_reg[5:3] == 3'h4) begin
        // offset calibration ties one input to both sides
        DIFF_MODE_O <= (sel_applied_reg >= SEL_CAL_IN0);
        GAIN_20X_O  <= (sel_applied_reg >= SEL_CAL_IN0) & sel_applied_reg[0];
        if (sel_applied_reg == SEL_CAL_IN0) begin
          POS_INPUT_O <= 3'h0;
          NEG_INPUT_O <= 3'h0;
        end else if (sel_applied_reg[2:1] == 2'h2) begin
          POS_INPUT_O <= 3'h3;
          NEG_INPUT_O <= 3'h3;
        end else if (sel_applied_reg[2:1] == 2'h3) begin
          POS_INPUT_O <= 3'h7;
          NEG_INPUT_O <= 3'h7;
        end else begin
          POS_INPUT_O <= 3'h0;
          NEG_INPUT_O <= 3'h0;
        end
      end else begin
        DIFF_MODE_O <= 1'b1;
        GAIN_20X_O  <= sel_applied_reg[0];
        if (sel_applied_reg[5]) begin
          // reversed pair: same table entry with sides swapped
          {NEG_INPUT_O, POS_INPUT_O} <=
            pair_of(sel_applied_reg[4:1] - 4'h4);
        end else begin
          {POS_INPUT_O, NEG_INPUT_O} <=
            pair_of(sel_applied_reg[4:1] - 4'h4);
        end
      end
    end
  end

endmodule

// [core/conv_ctrl_pkg.sv]
// constants shared by the analog converter control logic
package conv_ctrl_pkg;

  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_STATUS_CONTROL = 8'h06;
  localparam logic [7:0] IDX_INPUT_REF_SEL  = 8'h07;
  localparam logic [7:0] IDX_MODE_CONTROL   = 8'h08;

  // reset values
  localparam logic [7:0] RST_STATUS_CONTROL = 8'h00;
  localparam logic [7:0] RST_INPUT_REF_SEL  = 8'h00;
  localparam logic [7:0] RST_MODE_CONTROL   = 8'h00;

  // status/control field positions
  localparam int POS_ENABLE   = 7;
  localparam int POS_START    = 6;
  localparam int POS_AUTO_TRG = 5;
  localparam int POS_DONE     = 4;
  localparam int POS_IRQ_EN   = 3;
  localparam int POS_DIV_LO   = 0;
  // input/reference select field positions
  localparam int POS_REF_LO   = 6;
  localparam int POS_SEL_LO   = 0;
  // mode control field positions
  localparam int POS_FREE_RUN = 0;

  // reference field encodings
  localparam logic [1:0] REF_SUPPLY   = 2'h0;
  localparam logic [1:0] REF_EXTERNAL = 2'h1;
  localparam logic [1:0] REF_INTERNAL = 2'h2;
  localparam logic [1:0] REF_INT_PIN  = 2'h3;

  // selector landmarks
  localparam logic [5:0] SEL_GROUND   = 6'h20;
  localparam logic [5:0] SEL_BANDGAP  = 6'h21;
  localparam logic [5:0] SEL_TEMP     = 6'h22;
  localparam logic [5:0] SEL_CAL_IN0  = 6'h23;

  // conversion lengths in converter clock cycles
  localparam logic [4:0] CONV_CYCLES_NORMAL = 5'h0d;
  localparam logic [4:0] CONV_CYCLES_FIRST  = 5'h19;

  // prescaler division factors for codes 0..7
  localparam logic [7:0] DIV_FACTOR [8] = '{8'h02, 8'h02, 8'h04, 8'h08,
                                            8'h10, 8'h20, 8'h40, 8'h80};

  typedef enum logic {ST_IDLE, ST_CONVERT} conv_state_t;

endpackage

// [verif/conv_ctrl_properties.sv]
// concurrent checks on the converter control ports
`timescale 1ns/1ps
module conv_ctrl_properties (
  input wire logic        REF_CLK_I,        // system clock
  input wire logic        RST_B_I,          // reset, active low
  input wire logic        PSEL_I,           // apb select
  input wire logic        PENABLE_I,        // apb access
  input wire logic [31:0] PADDR_I,          // apb address
  input wire logic        PREADY_O,         // apb ready
  input wire logic        PSLVERR_O,        // apb error
  input wire logic        CONV_POWER_O,     // powered
  input wire logic        CONV_BUSY_O,      // converting
  input wire logic        CONV_INIT_O,      // long first conversion
  input wire logic        CONV_CLK_EN_O,    // converter tick
  input wire logic        CONV_DONE_O,      // completion pulse
  input wire logic        REF_SUPPLY_O,     // supply reference
  input wire logic        REF_EXTERNAL_O,   // pin reference
  input wire logic        REF_INTERNAL_O,   // internal reference
  input wire logic        REF_PIN_DRIVE_O,  // reference on pin
  input wire logic        DIFF_MODE_O,      // differential
  input wire logic        GAIN_20X_O,       // high gain
  input wire logic  [2:0] POS_INPUT_O       // positive input
);
  logic unmapped; // no register behind the address

  // decode of the three mapped words
  assign unmapped = !(PADDR_I inside {32'h18, 32'h1c, 32'h20});

  default clocking cb @(posedge REF_CLK_I); endclocking
  default disable iff (!RST_B_I);

  ////////////////////////////////////////////////////////////
  ready_high_a: assert property (PSEL_I |-> PREADY_O)
    else $error("ready low during a transfer");
  bad_addr_a: assert property (PSEL_I && PENABLE_I && unmapped |-> PSLVERR_O)
    else $error("no error on unmapped address");
  done_follows_a: assert property ($fell(CONV_BUSY_O) && CONV_POWER_O |-> CONV_DONE_O)
    else $error("completion without done pulse");
  done_single_a: assert property (CONV_DONE_O |=> !CONV_DONE_O)
    else $error("done pulse longer than one cycle");
  off_stops_a: assert property (!CONV_POWER_O |-> !CONV_BUSY_O && !CONV_INIT_O)
    else $error("conversion kept while disabled");
  off_no_tick_a: assert property (!CONV_POWER_O |=> !CONV_CLK_EN_O)
    else $error("converter tick while disabled");
  init_busy_a: assert property (CONV_INIT_O |-> CONV_BUSY_O)
    else $error("initialisation outside conversion");
  pin_drive_a: assert property (REF_PIN_DRIVE_O |-> REF_INTERNAL_O && !REF_SUPPLY_O)
    else $error("pin driven without internal reference");
  ref_onehot_a: assert property ($onehot0({REF_SUPPLY_O, REF_EXTERNAL_O, REF_INTERNAL_O}))
    else $error("two references at once");
  sel_hold_a: assert property (CONV_BUSY_O && $past(CONV_BUSY_O, 2) && !CONV_DONE_O
      && !$past(CONV_DONE_O) && !$past(CONV_DONE_O, 2)
      |-> $stable({DIFF_MODE_O, GAIN_20X_O, POS_INPUT_O, REF_INTERNAL_O, REF_SUPPLY_O}))
    else $error("selection changed mid conversion");

  // main scenarios reached
  cover property ($fell(CONV_BUSY_O) && CONV_POWER_O);
  cover property ($fell(CONV_BUSY_O) && !CONV_POWER_O);
  cover property (CONV_DONE_O && CONV_BUSY_O);
  cover property (REF_PIN_DRIVE_O);
endmodule

bind analog_converter_control conv_ctrl_properties u_conv_ctrl_properties (
  .REF_CLK_I, .RST_B_I, .PSEL_I, .PENABLE_I, .PADDR_I, .PREADY_O, .PSLVERR_O,
  .CONV_POWER_O, .CONV_BUSY_O, .CONV_INIT_O, .CONV_CLK_EN_O, .CONV_DONE_O,
  .REF_SUPPLY_O, .REF_EXTERNAL_O, .REF_INTERNAL_O, .REF_PIN_DRIVE_O,
  .DIFF_MODE_O, .GAIN_20X_O, .POS_INPUT_O
);

// [verif/analog_front_model.sv]
// analog front model: trigger source, reference pin and settling watch
`timescale 1ns/1ps
module analog_front_model (
  input  wire logic        clk_i,        // system clock
  input  wire logic        rst_b_i,      // reset, active low
  input  wire logic        busy_i,       // conversion running
  input  wire logic        tick_i,       // converter tick
  input  wire logic        diff_i,       // differential path
  input  wire logic [14:0] path_i,       // selection and reference seen
  input  wire logic        fire_i,       // request a trigger level
  input  wire logic        pin_drive_i,  // internal reference on pin
  output logic             trigger_o,    // trigger to the block
  output logic             ext_drive_o,  // external source on pin
  output logic             early_o       // start seen before settling
);
  logic [3:0]  ticks;     // ticks since the path last changed
  logic [14:0] path_reg;  // path one cycle ago

  // external source steps off the pin while the block drives it
  assign ext_drive_o = !pin_drive_i;

  // trigger comes from a register, as a real source would
  always_ff @(posedge clk_i) trigger_o <= fire_i;

  // gain stage settling: a differential start needs 13 quiet ticks
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ticks    <= 4'h0;
      path_reg <= 15'h0000;
      early_o  <= 1'b0;
    end else begin
      path_reg <= path_i;
      if (path_i != path_reg) ticks <= 4'h0;
      else if (tick_i && ticks < 4'hd) ticks <= ticks + 4'h1;
      if ($rose(busy_i) && diff_i && ticks < 4'hd) early_o <= 1'b1;
    end
  end
endmodule

// [verif/analog_converter_control_tb.sv]
// self-checking bench for the converter control block
`timescale 1ns/1ps
module analog_converter_control_tb import conv_ctrl_pkg::*; ;
  localparam logic [31:0] A_CTRL = {22'h0, IDX_STATUS_CONTROL, 2'h0};
  localparam logic [31:0] A_SEL  = {22'h0, IDX_INPUT_REF_SEL, 2'h0};
  localparam logic [31:0] A_MODE = {22'h0, IDX_MODE_CONTROL, 2'h0};
  logic        clk, rst_b, psel, penable, pwrite, fire, irq_ack, err;
  logic [31:0] paddr, pwdata, prdata, rd;
  logic        pready, pslverr, power, busy, init, tick, done, irq, trig, early;
  logic        r_sup, r_ext, r_int, r_pin, diff, gain, gnd, bg, temp;
  logic [2:0]  pos, neg;
  logic [10:0] path;
  int          n_errors, comparisons, cycles, t, n;
  // selector code and expected {diff,gain,pos,neg,ground,bandgap,temp}
  logic [16:0] tbl [12] = '{{6'h20, 11'h004}, {6'h21, 11'h002}, {6'h22, 11'h001},
    {6'h08, 11'h408}, {6'h09, 11'h608}, {6'h28, 11'h440}, {6'h3f, 11'h7f0},
    {6'h12, 11'h4e0}, {6'h23, 11'h600}, {6'h24, 11'h4d8}, {6'h27, 11'h7f8},
    {6'h1a, 11'h528}};
  logic [3:0]  ref_exp [4] = '{4'h8, 4'h4, 4'h2, 4'h3};

  assign path = {diff, gain, pos, neg, gnd, bg, temp};

  analog_converter_control u_analog_converter_control (
    .REF_CLK_I(clk), .RST_B_I(rst_b), .PSEL_I(psel), .PENABLE_I(penable),
    .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
    .PREADY_O(pready), .PSLVERR_O(pslverr), .TRIGGER_I(trig), .IRQ_ACK_I(irq_ack),
    .CONV_POWER_O(power), .CONV_BUSY_O(busy), .CONV_INIT_O(init), .CONV_CLK_EN_O(tick),
    .CONV_DONE_O(done), .CONV_IRQ_O(irq), .REF_SUPPLY_O(r_sup), .REF_EXTERNAL_O(r_ext),
    .REF_INTERNAL_O(r_int), .REF_PIN_DRIVE_O(r_pin), .DIFF_MODE_O(diff), .GAIN_20X_O(gain),
    .POS_INPUT_O(pos), .NEG_INPUT_O(neg), .GROUND_SEL_O(gnd), .BANDGAP_SEL_O(bg),
    .TEMP_SENSOR_EN_O(temp));

  analog_front_model u_analog_front_model (
    .clk_i(clk), .rst_b_i(rst_b), .busy_i(busy), .tick_i(tick), .diff_i(diff),
    .path_i({path, r_sup, r_ext, r_int, r_pin}), .fire_i(fire), .pin_drive_i(r_pin),
    .trigger_o(trig), .ext_drive_o(), .early_o(early));

  ////////////////////////////////////////////////////////////
  task automatic finish_test;
    $display("mismatches %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // one apb transfer; request held until pready is seen at an edge
  task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d);
    @(posedge clk);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rchk(input logic [31:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(rd, exp);
  endtask

  // settle past the edge so registered outputs have landed
  task automatic step(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask

  // ticks seen while busy, until the conversion ends
  task automatic convert(output int tk);
    tk = 0;
    #1;
    for (int w = 0; w < 8 && busy !== 1'b1; w++) step(1);
    while (busy === 1'b1) begin
      if (tick === 1'b1) tk++;
      step(1);
    end
  endtask

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // hang guard
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_errors++;
      finish_test;
    end
  end

  ////////////////////////////////////////////////////////////
  initial begin
    {psel, penable, pwrite, fire, irq_ack, rst_b} = 6'h00;
    paddr = 32'h0;
    pwdata = 32'h0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    rchk(A_CTRL, 32'h0);
    rchk(A_SEL, 32'h0);
    rchk(A_MODE, 32'h0);
    apb(1'b1, A_SEL, 32'hff);
    rchk(A_SEL, 32'hff);
    apb(1'b1, 32'h24, 32'hff);
    check(err, 1'b1);
    rchk(32'h24, 32'h0);
    $display("test registers done");
    for (int r = 0; r < 4; r++) begin
      apb(1'b1, A_SEL, 32'(r) << 6);
      step(3);
      check({r_sup, r_ext, r_int, r_pin}, ref_exp[r]);
    end
    for (int i = 0; i < 8; i++) begin
      apb(1'b1, A_SEL, 32'(i));
      step(3);
      check(32'(path), 32'(i) << 6);
    end
    for (int k = 0; k < 12; k++) begin
      apb(1'b1, A_SEL, 32'(tbl[k][16:11]));
      step(3);
      check(32'(path), 32'(tbl[k][10:0]));
    end
    $display("test selection done");
    for (int c = 0; c < 8; c++) begin
      apb(1'b1, A_CTRL, 32'h80 | 32'(c));
      for (int g = 0; g < 2; g++) begin
        while (tick !== 1'b1) step(1);
        n = 0;
        do begin step(1); n++; end while (tick !== 1'b1);
      end
      check(n, c < 2 ? 2 : 1 << c);
    end
    apb(1'b1, A_CTRL, 32'h0);
    apb(1'b1, A_SEL, 32'h05);
    apb(1'b1, A_CTRL, 32'hc1);
    #1;
    check(init, 1'b1);
    convert(t);
    check(t, 25);
    rchk(A_CTRL, 32'h91);
    apb(1'b1, A_CTRL, 32'h89);
    step(1);
    check(busy, 1'b0);
    check(irq, 1'b1);
    @(posedge clk);
    irq_ack <= 1'b1;
    @(posedge clk);
    irq_ack <= 1'b0;
    rchk(A_CTRL, 32'h89);
    apb(1'b1, A_CTRL, 32'hc9);
    apb(1'b1, A_SEL, 32'h89);
    step(2);
    check({path, r_sup}, {11'h140, 1'b1});
    check(init, 1'b0);
    convert(t);
    step(3);
    check({path, r_int}, {11'h608, 1'b1});
    rchk(A_CTRL, 32'h99);
    apb(1'b1, A_CTRL, 32'h99);
    rchk(A_CTRL, 32'h89);
    $display("test conversion done");
    step(30);
    apb(1'b1, A_CTRL, 32'hc9);
    rchk(A_CTRL, 32'hc9);
    apb(1'b1, A_CTRL, 32'h09);
    step(2);
    check({busy, power}, 2'b00);
    rchk(A_CTRL, 32'h09);
    apb(1'b1, A_CTRL, 32'hc9);
    convert(t);
    check(t, 25);
    $display("test abort done");
    apb(1'b1, A_CTRL, 32'hb9);
    fire <= 1'b1;
    repeat (4) @(posedge clk);
    fire <= 1'b0;
    convert(t);
    check(t, 13);
    apb(1'b1, A_MODE, 32'h1);
    apb(1'b1, A_CTRL, 32'hf9);
    step(2);
    n = 0;
    t = 0;
    repeat (100) begin
      if (done === 1'b1) n++;
      if (busy !== 1'b1) t++;
      step(1);
    end
    check(t, 32'h0);
    check(32'(n > 2), 32'h1);
    apb(1'b1, A_CTRL, 32'h09);
    step(2);
    check(busy, 1'b0);
    check(early, 1'b0);
    $display("test trigger done");
    finish_test;
  end
endmodule
